/* File: core/bsp_sram_port.sv */
// burst-of-four separate-port memory, device side
// Contract
// - address and commands are taken on rising K, write data on K and K#.
// - echo clocks run freely, edge matched to read data, even when idle.
// - with the bypass input low the loop is bypassed and its lock is lost.
// - with the bypass input high the loop runs and locks after lock time.
// - with the loop off read latency is one cycle; clock kept to 167 MHz.
// - a read-valid flag marks read data and moves with the echo clocks.
// - address is sampled on rising K and ignored when nothing is selected.
// - write data is 18 bits narrow or 36 bits wide, upper inputs unused.
// - read data is driven only for reads, 18 or 36 bits wide.
// - write select low on rising K registers the address, starts a write.
// - read select low on rising K registers the address, starts a read.
// - byte-write masks go with their beat; low writes, high keeps a byte.
// - with the loop running the first read beat comes two cycles later.
// - after a loop reset lock needs 2048 stable input clock cycles.
`timescale 1ns/1ps
`include "bsp_defines.svh"
module bsp_sram_port
  import bsp_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   k_clk,
  input  wire logic                   k_n_clk,
  input  wire logic                   rd_sel_n,
  input  wire logic                   wr_sel_n,
  input  wire logic [`BSP_ADDR_W-1:0] addr_in,
  input  wire logic [`BSP_LANES-1:0]  byte_wr_mask_n,
  input  wire logic [`BSP_DATA_W-1:0] wr_data,
  input  wire logic                   loop_bypass_n,
  output logic                        echo_timing_out,
  output logic                        echo_timing_out_inv,
  output logic                        read_valid_flag,
  output logic [`BSP_DATA_W-1:0]      read_data,
  output logic                        read_data_oe,
  output logic                        dll_locked,
  output logic                        trace_valid,
  input  wire logic                   trace_ready,
  output logic [`BSP_ADDR_W-1:0]      trace_addr,
  output logic                        trace_lost
);

  // byte-masked merge of one word
  function automatic logic [`BSP_DATA_W-1:0] bsp_merge(
    input logic [`BSP_DATA_W-1:0] old_w,
    input logic [`BSP_DATA_W-1:0] new_w,
    input logic [`BSP_LANES-1:0]  mask_n
  );
    logic [`BSP_DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < `BSP_LANES; i++)
    begin
      if (!mask_n[i])
        res[i*`BSP_LANE_W +: `BSP_LANE_W] = new_w[i*`BSP_LANE_W +: `BSP_LANE_W];
    end
    return res;
  endfunction

  // array index of one beat of a burst
  function automatic logic [`BSP_IDX_W-1:0] bsp_idx(
    input logic [`BSP_ADDR_W-1:0] base,
    input logic [1:0]             beat
  );
    return {base, beat};
  endfunction

  // narrow configuration ignores the upper inputs
  function automatic logic [`BSP_DATA_W-1:0] bsp_width(
    input logic [`BSP_DATA_W-1:0] w
  );
    logic [`BSP_DATA_W-1:0] res;
    res = w;
    if (!`BSP_WIDE_CFG)
      res[`BSP_DATA_W-1:`BSP_NARROW_W] = '0;
    return res;
  endfunction

  logic                   k_rst_n;
  logic                   dll_run;
  logic                   rd_sel_s_reg;
  logic                   wr_sel_s_reg;
  logic [`BSP_ADDR_W-1:0] addr_s_reg;
  logic [`BSP_DATA_W-1:0] d_k_reg;
  logic [`BSP_LANES-1:0]  m_k_reg;
  logic [`BSP_DATA_W-1:0] d_kn_reg;
  logic [`BSP_LANES-1:0]  m_kn_reg;
  logic [`BSP_DATA_W-1:0] mem_reg [0:`BSP_WORDS-1];
  bsp_wr_state_t          wr_state_reg;
  logic [`BSP_ADDR_W-1:0] wr_base_reg;
  bsp_rd_state_t          rd_state_reg;
  logic [`BSP_ADDR_W-1:0] rd_base_reg;
  logic                   issue_first;
  logic                   issue_second;
  logic [`BSP_ADDR_W-1:0] issue_base;
  logic [`BSP_DATA_W-1:0] rise_q_reg;
  logic [`BSP_DATA_W-1:0] fall_pend_reg;
  logic [`BSP_DATA_W-1:0] fall_q_reg;
  logic                   vld_reg;
  logic                   phase_k_reg;
  logic                   phase_kn_reg;
  logic [`BSP_LOCK_CNT_W-1:0] lock_cnt_reg;
  logic                   locked_k_reg;
  logic                   tr_req_reg;
  logic [`BSP_ADDR_W-1:0] tr_addr_reg;
  logic                   lost_k_reg;
  logic                   tr_ack_s;
  logic                   tr_req_s;
  logic                   tr_ack_reg;
  logic                   locked_s;
  logic                   lost_s;
  logic                   tr_in_valid;
  logic                   tr_in_ready;
  logic                   rd_sel_d_reg;
  logic [`BSP_ADDR_W-1:0] addr_d_reg;
  logic                   rd_cmd;
  logic [`BSP_ADDR_W-1:0] rd_cmd_addr;

  // reset and pin-level crossings into the link domain
  bsp_sync2 u_k_rst (
    .clk   (k_clk),
    .rst_n (1'b1),
    .d     (nrst),
    .q     (k_rst_n)
  );

  bsp_sync2 u_bypass (
    .clk   (k_clk),
    .rst_n (k_rst_n),
    .d     (loop_bypass_n),
    .q     (dll_run)
  );

  // command and address sampling on rising K
  always_ff @(posedge k_clk)
  begin
    if (!k_rst_n)
    begin
      rd_sel_s_reg <= 1'b1;
      wr_sel_s_reg <= 1'b1;
      addr_s_reg   <= '0;
      rd_sel_d_reg <= 1'b1;
      addr_d_reg   <= '0;
    end
    else
    begin
      rd_sel_s_reg <= rd_sel_n;
      wr_sel_s_reg <= wr_sel_n;
      if (!rd_sel_n || !wr_sel_n)
        addr_s_reg <= addr_in;
      rd_sel_d_reg <= rd_sel_s_reg;
      addr_d_reg   <= addr_s_reg;
    end
  end

  // write beats: first and third on K, second and fourth on K#
  always_ff @(posedge k_clk)
  begin
    d_k_reg <= bsp_width(wr_data);
    m_k_reg <= byte_wr_mask_n;
  end

  always_ff @(posedge k_n_clk)
  begin
    d_kn_reg <= bsp_width(wr_data);
    m_kn_reg <= byte_wr_mask_n;
  end

  // write burst sequencing
  always_ff @(posedge k_clk)
  begin
    if (!k_rst_n)
    begin
      wr_state_reg <= bsp_ws_idle;
      wr_base_reg  <= '0;
    end
    else
    begin
      unique case (wr_state_reg)
        bsp_ws_a:
          wr_state_reg <= bsp_ws_b;
        bsp_ws_idle, bsp_ws_b:
          if (!wr_sel_s_reg)
          begin
            wr_base_reg  <= addr_s_reg;
            wr_state_reg <= bsp_ws_a;
          end
          else
            wr_state_reg <= bsp_ws_idle;
        default:
          wr_state_reg <= bsp_ws_idle;
      endcase
    end
  end

  // array update, two beats per edge
  always_ff @(posedge k_clk)
  begin
    if (wr_state_reg == bsp_ws_a)
    begin
      mem_reg[bsp_idx(wr_base_reg, 2'h0)] <=
        bsp_merge(mem_reg[bsp_idx(wr_base_reg, 2'h0)], d_k_reg, m_k_reg);
      mem_reg[bsp_idx(wr_base_reg, 2'h1)] <=
        bsp_merge(mem_reg[bsp_idx(wr_base_reg, 2'h1)], d_kn_reg, m_kn_reg);
    end
    else if (wr_state_reg == bsp_ws_b)
    begin
      mem_reg[bsp_idx(wr_base_reg, 2'h2)] <=
        bsp_merge(mem_reg[bsp_idx(wr_base_reg, 2'h2)], d_k_reg, m_k_reg);
      mem_reg[bsp_idx(wr_base_reg, 2'h3)] <=
        bsp_merge(mem_reg[bsp_idx(wr_base_reg, 2'h3)], d_kn_reg, m_kn_reg);
    end
  end

  // loop running: read command delayed one cycle, keeps back-to-back bursts
  assign rd_cmd      = dll_run ? !rd_sel_d_reg : !rd_sel_s_reg;
  assign rd_cmd_addr = dll_run ? addr_d_reg : addr_s_reg;

  // read issue decode
  always_comb
  begin
    issue_first  = 1'b0;
    issue_second = 1'b0;
    issue_base   = rd_base_reg;
    unique case (rd_state_reg)
      bsp_rs_first:
        issue_second = 1'b1;
      bsp_rs_idle, bsp_rs_second:
        if (rd_cmd)
        begin
          issue_first = 1'b1;
          issue_base  = rd_cmd_addr;
        end
      default:
        issue_first = 1'b0;
    endcase
  end

  // read burst sequencing
  always_ff @(posedge k_clk)
  begin
    if (!k_rst_n)
    begin
      rd_state_reg <= bsp_rs_idle;
      rd_base_reg  <= '0;
    end
    else
    begin
      unique case (rd_state_reg)
        bsp_rs_first:
          rd_state_reg <= bsp_rs_second;
        bsp_rs_idle, bsp_rs_second:
          if (rd_cmd)
          begin
            rd_base_reg  <= rd_cmd_addr;
            rd_state_reg <= bsp_rs_first;
          end
          else
            rd_state_reg <= bsp_rs_idle;
        default:
          rd_state_reg <= bsp_rs_idle;
      endcase
    end
  end

  // read data registers, rising half and falling half
  always_ff @(posedge k_clk)
  begin
    if (!k_rst_n)
    begin
      rise_q_reg    <= '0;
      fall_pend_reg <= '0;
      vld_reg       <= 1'b0;
    end
    else
    begin
      vld_reg <= issue_first | issue_second;
      if (issue_first)
      begin
        rise_q_reg    <= mem_reg[bsp_idx(issue_base, 2'h0)];
        fall_pend_reg <= mem_reg[bsp_idx(issue_base, 2'h1)];
      end
      else if (issue_second)
      begin
        rise_q_reg    <= mem_reg[bsp_idx(issue_base, 2'h2)];
        fall_pend_reg <= mem_reg[bsp_idx(issue_base, 2'h3)];
      end
    end
  end

  always_ff @(posedge k_n_clk)
  begin
    if (!k_rst_n)
      fall_q_reg <= '0;
    else
      fall_q_reg <= fall_pend_reg;
  end

  // echo phase toggles, one per clock edge
  always_ff @(posedge k_clk)
  begin
    if (!k_rst_n)
      phase_k_reg <= 1'b0;
    else
      phase_k_reg <= ~phase_kn_reg;
  end

  always_ff @(posedge k_n_clk)
  begin
    if (!k_rst_n)
      phase_kn_reg <= 1'b0;
    else
      phase_kn_reg <= phase_k_reg;
  end

  // echo, valid and data pins share the same edges
  assign echo_timing_out     = phase_k_reg ^ phase_kn_reg;
  assign echo_timing_out_inv = ~(phase_k_reg ^ phase_kn_reg);
  assign read_valid_flag     = vld_reg;
  assign read_data_oe        = vld_reg;
  assign read_data           = !vld_reg ? '0 :
                               (phase_k_reg ^ phase_kn_reg) ? rise_q_reg :
                               fall_q_reg;

  // loop lock counter
  always_ff @(posedge k_clk)
  begin
    if (!k_rst_n || !dll_run)
    begin
      lock_cnt_reg <= '0;
      locked_k_reg <= 1'b0;
    end
    else if (lock_cnt_reg == `BSP_LOCK_CNT_W'(`BSP_LOCK_CYCLES - 1))
      locked_k_reg <= 1'b1;
    else
      lock_cnt_reg <= lock_cnt_reg + 1'b1;
  end

  // finished write bursts offered to the trace side
  bsp_sync2 u_ack (
    .clk   (k_clk),
    .rst_n (k_rst_n),
    .d     (tr_ack_reg),
    .q     (tr_ack_s)
  );

  always_ff @(posedge k_clk)
  begin
    if (!k_rst_n)
    begin
      tr_req_reg  <= 1'b0;
      tr_addr_reg <= '0;
      lost_k_reg  <= 1'b0;
    end
    else if (wr_state_reg == bsp_ws_b)
    begin
      if (tr_req_reg == tr_ack_s)
      begin
        tr_addr_reg <= wr_base_reg;
        tr_req_reg  <= ~tr_req_reg;
      end
      else
        lost_k_reg <= 1'b1;
    end
  end

  // system clock side
  bsp_sync2 u_req (
    .clk   (clk),
    .rst_n (nrst),
    .d     (tr_req_reg),
    .q     (tr_req_s)
  );

  bsp_sync2 u_lock (
    .clk   (clk),
    .rst_n (nrst),
    .d     (locked_k_reg),
    .q     (locked_s)
  );

  bsp_sync2 u_lost (
    .clk   (clk),
    .rst_n (nrst),
    .d     (lost_k_reg),
    .q     (lost_s)
  );

  assign tr_in_valid = tr_req_s ^ tr_ack_reg;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      tr_ack_reg <= 1'b0;
      dll_locked <= 1'b0;
      trace_lost <= 1'b0;
    end
    else
    begin
      dll_locked <= locked_s;
      trace_lost <= lost_s;
      if (tr_in_valid && tr_in_ready)
        tr_ack_reg <= ~tr_ack_reg;
    end
  end

  bsp_fifo2 #(
    .W (`BSP_ADDR_W)
  ) u_trace_buf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (tr_in_valid),
    .in_ready  (tr_in_ready),
    .in_data   (tr_addr_reg),
    .out_valid (trace_valid),
    .out_ready (trace_ready),
    .out_data  (trace_addr)
  );

endmodule // bsp_sram_port

/* File: core/bsp_defines.svh */
// constants for the burst-of-four separate-port memory block
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH

`define BSP_DATA_W      36
`define BSP_NARROW_W    18
`define BSP_LANES       4
`define BSP_LANE_W      9
`define BSP_WIDE_CFG    1'b1
`define BSP_ADDR_W      4
`define BSP_IDX_W       6
`define BSP_WORDS       64
`define BSP_LOCK_CYCLES 2048
`define BSP_LOCK_CNT_W  12

`endif

/* File: core/bsp_pkg.sv */
// types for the burst-of-four separate-port memory block
package bsp_pkg;

  typedef enum logic [1:0] {
    bsp_ws_idle = 2'b00,
    bsp_ws_a    = 2'b01,
    bsp_ws_b    = 2'b10
  } bsp_wr_state_t;

  typedef enum logic [1:0] {
    bsp_rs_idle   = 2'b00,
    bsp_rs_wait   = 2'b01,
    bsp_rs_first  = 2'b10,
    bsp_rs_second = 2'b11
  } bsp_rd_state_t;

endpackage

/* File: core/bsp_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module bsp_sync2
  import bsp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // bsp_sync2

/* File: core/bsp_fifo2.sv */
// two-entry buffer, head entry drives the output
`timescale 1ns/1ps
module bsp_fifo2
  import bsp_pkg::*;
#(
  parameter int W = 4
)
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic         spare_valid_reg;
  logic [W-1:0] spare_data_reg;
  logic         push;
  logic         pop;

  assign in_ready = ~spare_valid_reg;
  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out_valid       <= 1'b0;
      spare_valid_reg <= 1'b0;
      out_data        <= '0;
      spare_data_reg  <= '0;
    end
    else if (pop)
    begin
      if (spare_valid_reg)
      begin
        out_data        <= spare_data_reg;
        spare_valid_reg <= 1'b0;
      end
      else if (push)
        out_data <= in_data;
      else
        out_valid <= 1'b0;
    end
    else if (push)
    begin
      if (!out_valid)
      begin
        out_data  <= in_data;
        out_valid <= 1'b1;
      end
      else
      begin
        spare_data_reg  <= in_data;
        spare_valid_reg <= 1'b1;
      end
    end
  end
endmodule // bsp_fifo2

/* File: verif/bsp_sram_port_checker.sv */
// assertion checker for the burst-of-four memory port
`timescale 1ns/1ps
`include "bsp_defines.svh"
module bsp_sram_port_checker
  import bsp_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire logic                   k_clk,
  input wire logic                   k_n_clk,
  input wire logic                   rd_sel_n,
  input wire logic                   loop_bypass_n,
  input wire logic                   echo_timing_out,
  input wire logic                   echo_timing_out_inv,
  input wire logic                   read_valid_flag,
  input wire logic [`BSP_DATA_W-1:0] read_data,
  input wire logic                   read_data_oe,
  input wire logic                   dll_locked,
  input wire logic                   trace_valid,
  input wire logic                   trace_ready,
  input wire logic [`BSP_ADDR_W-1:0] trace_addr
);
  logic [9:0] hi_cnt_reg;
  // clk cycles spent with the loop running
  always_ff @(posedge clk)
  begin
    if (!nrst || !loop_bypass_n)
      hi_cnt_reg <= 10'h000;
    else if (hi_cnt_reg != 10'h3FF)
      hi_cnt_reg <= hi_cnt_reg + 10'h001;
  end
  AST_ECHO_HI: assert property (@(posedge k_n_clk)
    disable iff (!nrst) $past(nrst, 8) |-> echo_timing_out)
    else $error("echo not high");
  AST_ECHO_CMP: assert property (@(posedge k_clk)
    disable iff (!nrst) echo_timing_out_inv == !echo_timing_out)
    else $error("echo pair not complementary");
  AST_OE: assert property (@(posedge k_n_clk)
    disable iff (!nrst) read_data_oe == read_valid_flag)
    else $error("drive enable differs from valid");
  AST_Q_IDLE: assert property (@(posedge k_n_clk)
    disable iff (!nrst) !read_valid_flag |-> read_data == '0)
    else $error("read data driven while idle");
  AST_LAT2: assert property (@(posedge k_clk) disable iff (!nrst)
    !rd_sel_n && $past(rd_sel_n) && loop_bypass_n &&
    $past(loop_bypass_n, 4) |-> ##3 read_valid_flag [*2])
    else $error("read latency two broken");
  AST_LAT1: assert property (@(posedge k_clk) disable iff (!nrst)
    !rd_sel_n && $past(rd_sel_n) && !loop_bypass_n &&
    !$past(loop_bypass_n, 4) |-> ##2 read_valid_flag [*2])
    else $error("read latency one broken");
  AST_CAUSE: assert property (@(posedge k_clk) disable iff (!nrst)
    $rose(read_valid_flag) |-> !$past(rd_sel_n, 2) || !$past(rd_sel_n, 3))
    else $error("valid without read");
  AST_TR_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    trace_valid && !trace_ready |=> trace_valid && $stable(trace_addr))
    else $error("trace word not held");
  AST_LOCK_OFF: assert property (@(posedge clk) disable iff (!nrst)
    (!loop_bypass_n) [*8] |-> !dll_locked)
    else $error("lock kept while bypassed");
  AST_LOCK_EARLY: assert property (@(posedge clk)
    disable iff (!nrst) dll_locked && loop_bypass_n &&
    $past(loop_bypass_n, 8) |-> hi_cnt_reg > 10'h2F8)
    else $error("lock too early");
  AST_LOCK_LATE: assert property (@(posedge clk)
    disable iff (!nrst) hi_cnt_reg > 10'h320 |-> dll_locked)
    else $error("lock missing");
  C_RD2: cover property (@(posedge k_clk) disable iff (!nrst)
    !rd_sel_n && loop_bypass_n);
  C_STALL: cover property (@(posedge clk) disable iff (!nrst)
    trace_valid && !trace_ready);
  C_LOCK: cover property (@(posedge clk) disable iff (!nrst)
    $rose(dll_locked));
endmodule // bsp_sram_port_checker

bind bsp_sram_port bsp_sram_port_checker u_chk (
  .clk(clk), .nrst(nrst), .k_clk(k_clk), .k_n_clk(k_n_clk),
  .rd_sel_n(rd_sel_n), .loop_bypass_n(loop_bypass_n),
  .echo_timing_out(echo_timing_out),
  .echo_timing_out_inv(echo_timing_out_inv),
  .read_valid_flag(read_valid_flag), .read_data(read_data),
  .read_data_oe(read_data_oe), .dll_locked(dll_locked),
  .trace_valid(trace_valid), .trace_ready(trace_ready),
  .trace_addr(trace_addr)
);

/* File: verif/bsp_ctl_model.sv */
// controller model: link clocks, commands and write beats
`timescale 1ns/1ps
`include "bsp_defines.svh"
module bsp_ctl_model
  import bsp_pkg::*;
(
  output logic                   k_clk,
  output logic                   k_n_clk,
  output logic                   rd_sel_n,
  output logic                   wr_sel_n,
  output logic [`BSP_ADDR_W-1:0] addr_in,
  output logic [`BSP_LANES-1:0]  byte_wr_mask_n,
  output logic [`BSP_DATA_W-1:0] wr_data
);
  logic [39:0] beat_q[$];
  initial
  begin
    k_clk = 1'b0;
    rd_sel_n = 1'b1;
    wr_sel_n = 1'b1;
    addr_in = 4'h0;
    {byte_wr_mask_n, wr_data} = 40'hF_0000_0000;
  end
  always #7.5 k_clk = ~k_clk;
  assign k_n_clk = ~k_clk;
  // one beat per K or K# rise, scrambled when idle
  always @(k_clk)
  begin
    if (beat_q.size() > 0)
      {byte_wr_mask_n, wr_data} <= beat_q.pop_front();
    else
      {byte_wr_mask_n, wr_data} <= ~{byte_wr_mask_n, wr_data};
  end
  task automatic cmd(input logic wr, input logic rd, input logic [3:0] a,
    input logic [15:0] m, input logic [143:0] d);
    @(posedge k_clk);
    wr_sel_n <= ~wr;
    rd_sel_n <= ~rd;
    addr_in <= a;
    @(posedge k_clk);
    wr_sel_n <= 1'b1;
    rd_sel_n <= 1'b1;
    addr_in <= ~a;
    #1;
    // beats start at the next K# rise, first one seen at K after command
    if (wr)
      for (int i = 0; i < 4; i++)
        beat_q.push_back({m[4*i +: 4], d[36*i +: 36]});
  endtask
endmodule // bsp_ctl_model

/* File: verif/tb_bsp_sram_port.sv */
// self-checking bench for the burst-of-four memory port
`timescale 1ns/1ps
`include "bsp_defines.svh"
module tb_bsp_sram_port;
  logic                   clk, nrst, loop_bypass_n, trace_ready;
  logic                   k_clk, k_n_clk, rd_sel_n, wr_sel_n;
  logic [`BSP_ADDR_W-1:0] addr_in, trace_addr;
  logic [`BSP_LANES-1:0]  byte_wr_mask_n;
  logic [`BSP_DATA_W-1:0] wr_data, read_data;
  logic                   echo_timing_out, echo_timing_out_inv;
  logic                   read_valid_flag, read_data_oe, dll_locked;
  logic                   trace_valid, trace_lost;
  logic [`BSP_DATA_W-1:0] mem [`BSP_WORDS];
  logic [`BSP_DATA_W-1:0] rd_q[$];
  logic [`BSP_ADDR_W-1:0] tr_q[$];
  int                     error_cnt, n_tests, seed;

  bsp_ctl_model u_ctl (.k_clk(k_clk), .k_n_clk(k_n_clk),
    .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr_in(addr_in),
    .byte_wr_mask_n(byte_wr_mask_n), .wr_data(wr_data));
  bsp_sram_port u_dut (.clk(clk), .nrst(nrst), .k_clk(k_clk),
    .k_n_clk(k_n_clk), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n),
    .addr_in(addr_in), .byte_wr_mask_n(byte_wr_mask_n),
    .wr_data(wr_data), .loop_bypass_n(loop_bypass_n),
    .echo_timing_out(echo_timing_out),
    .echo_timing_out_inv(echo_timing_out_inv),
    .read_valid_flag(read_valid_flag), .read_data(read_data),
    .read_data_oe(read_data_oe), .dll_locked(dll_locked),
    .trace_valid(trace_valid), .trace_ready(trace_ready),
    .trace_addr(trace_addr), .trace_lost(trace_lost));

  always #20 clk = ~clk;
  task automatic fail(input string s);
    error_cnt++;
    $display("CHECK FAILED %0t %s", $time, s);
  endtask
  task automatic chk_rd(input logic [35:0] g, input logic [35:0] e);
    n_tests++;
    if (g !== e) fail("read beat");
  endtask
  task automatic chk_tr(input logic [3:0] g, input logic [3:0] e);
    n_tests++;
    if (g !== e) fail("trace address");
  endtask
  task automatic chk_f(input logic g, input logic e, input string s);
    n_tests++;
    if (g !== e) fail(s);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] m);
    logic [159:0] r;
    r = {$random(seed), $random(seed), $random(seed), $random(seed),
      $random(seed)};
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 4; j++)
        if (!m[4*i+j])
          mem[{a, i[1:0]}][9*j +: 9] = r[36*i+9*j +: 9];
    tr_q.push_back(a);
    u_ctl.cmd(1'b1, 1'b0, a, m, r[143:0]);
  endtask
  task automatic rd(input logic [3:0] a);
    for (int i = 0; i < 4; i++)
      rd_q.push_back(mem[{a, i[1:0]}]);
    u_ctl.cmd(1'b0, 1'b1, a, 16'hFFFF, 144'h0);
  endtask

  // read beats, mid half-period of each K and K# phase
  always @(posedge k_clk or posedge k_n_clk)
  begin
    #4;
    if (read_valid_flag === 1'b1)
      if (rd_q.size() == 0)
        fail("extra beat");
      else
        chk_rd(read_data, rd_q.pop_front());
  end
  // handshake seen mid-cycle, taken at the next rising clk
  always @(negedge clk)
  begin
    if (nrst === 1'b1 && trace_valid === 1'b1 && trace_ready === 1'b1)
      if (tr_q.size() == 0)
        fail("extra trace");
      else
        chk_tr(trace_addr, tr_q.pop_front());
  end

  initial
  begin
    #200000;
    fail("timeout");
    close_out();
  end
  initial
  begin
    seed = 32'h0677D449;
    clk = 1'b0;
    nrst = 1'b0;
    loop_bypass_n = 1'b0;
    trace_ready = 1'b1;
    repeat (10) @(posedge clk);
    chk_f(echo_timing_out_inv, 1'b1, "echo inv");
    chk_f(read_valid_flag, 1'b0, "valid in reset");
    nrst <= 1'b1;
    $display("test reset done");
    repeat (6) @(posedge clk);
    wr(4'h5, 16'h0000);
    repeat (4) @(posedge clk);
    rd(4'h5);
    repeat (4) @(posedge clk);
    chk_f(dll_locked, 1'b0, "lock while bypassed");
    $display("test latency one done");
    loop_bypass_n <= 1'b1;
    repeat (700) @(posedge clk);
    chk_f(dll_locked, 1'b0, "early lock");
    repeat (120) @(posedge clk);
    chk_f(dll_locked, 1'b1, "no lock");
    $display("test lock done");
    for (int i = 0; i < 4; i++)
    begin
      wr(i[3:0], 16'h0000);
      repeat (8) @(posedge clk);
      wr(i[3:0], 16'($random(seed)));
      repeat (8) @(posedge clk);
    end
    for (int i = 0; i < 4; i++)
      rd(i[3:0]);
    repeat (8) @(posedge clk);
    $display("test latency two done");
    trace_ready <= 1'b0;
    for (int i = 8; i < 14; i++)
    begin
      wr(i[3:0], 16'h0000);
      repeat (8) @(posedge clk);
    end
    chk_f(trace_valid, 1'b1, "trace not held");
    chk_f(trace_lost, 1'b1, "no drop flagged");
    trace_ready <= 1'b1;
    repeat (10) @(posedge clk);
    chk_f(trace_valid, 1'b0, "not drained");
    tr_q.delete();
    $display("test trace done");
    chk_f(rd_q.size() == 0, 1'b1, "beats missing");
    close_out();
  end
endmodule // tb_bsp_sram_port
